// *** lwm_params.svh ***
`ifndef LWM_PARAMS_SVH
`define LWM_PARAMS_SVH

`define LWM_CLK_HZ 25000000
`define LWM_CHIP_NS 500
`define LWM_QSYM_NS 4000
// Quarter symbol: 16 us symbol / 4
`define LWM_QSYM_CYC ((`LWM_QSYM_NS * 25) / 1000)
`define LWM_CHIP_CYC ((`LWM_CHIP_NS * 25) / 1000)
`define LWM_TRACE_BPS 500000
`define LWM_TRACE_CYC (`LWM_CLK_HZ / `LWM_TRACE_BPS)
`define LWM_BACKOFF_CYC (20 * `LWM_QSYM_CYC * 4)
`define LWM_RSSI_WIN 8
`define LWM_PRE_SYMS 8
`define LWM_SFD 8'hA7
`define LWM_CRC_POLY 16'h8408
`define LWM_STAT_BYTES 5
`define LWM_FIFO_DEPTH 16

`endif

// *** lwm_pkg.sv ***
package lwm_pkg;
   typedef enum logic [2:0] {LWM_TX_IDLE, LWM_TX_BACKOFF, LWM_TX_CCA, LWM_TX_PRE,
      LWM_TX_DATA, LWM_TX_CRC, LWM_TX_WAIT_ACK} lwm_tx_t;
   typedef enum logic [1:0] {LWM_RX_HUNT, LWM_RX_LEN, LWM_RX_BODY, LWM_RX_STAT} lwm_rx_t;
endpackage : lwm_pkg

// *** lwm_fifo.sv ***
module lwm_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 16
)(
   input wire logic clk,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic [AW:0] cnt_ff, nxt_cnt;
   logic push, pop;

   assign in_ready = (cnt_ff != DEPTH[AW:0]);
   assign out_valid = (cnt_ff != '0);
   assign out_data = mem_ff[rd_ff];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb
   begin
      nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
      nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
      nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end
      else
      begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
         cnt_ff <= nxt_cnt;
      end
   end

   // Storage has no reset; data is only read when counted valid
   always_ff @(posedge clk)
   begin
      if (push)
         mem_ff[wr_ff] <= in_data;
   end
endmodule : lwm_fifo

// *** lwm_mac_baseband.sv ***
`include "lwm_params.svh"
// Notes on behaviour
// - Gain updates every quarter symbol before preamble.
// - Gain frozen after preamble until rx_done of an accepted packet with preamble_seen low.
// - Chips despread to symbols, buffered, to MAC.
// - Strength computed per eight symbols and packet end.
// - Busy when strength above threshold.
// - Symbol mapped to its 32-chip sequence.
// - Transmit indicator high in transmit; companion inverted.
// - Software gives buffer; backoff, transmit mode, assessment.
// - Clear channel: fetch bytes, CRC, symbols, remainder.
// - Preamble and delimiter inserted automatically.
// - Receive default; rejected frames get no rx_done, but bytes up to the failing address byte still reach RAM.
// - Receive symbols, CRC, assemble bytes, write RAM.
// - Append quality, strength, gain, stamp, status.
// - Time stamp every sent packet and every accepted received packet.
// - Slotted or unslotted timing; symbol timer events.
// - Trace port copies traffic, never injects.
// - Trace is 500 kbps serial with frame signal.
// - Random source gives 16-bit noise-derived values.
module lwm_mac_baseband
   import lwm_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic rx_chip_valid,
   input wire logic [31:0] rx_chip_word,
   input wire logic preamble_seen,
   input wire logic [7:0] rssi_sample,
   input wire logic [7:0] cca_threshold,
   output logic [7:0] gain_loop,
   output logic [7:0] rssi_value,
   output logic cca_busy,
   output logic tx_chip_valid,
   output logic [31:0] tx_chip_word,
   output logic pa_transmit_indicator,
   output logic pa_transmit_indicator_inverted,
   input wire logic tx_start,
   input wire logic [15:0] tx_buf_addr,
   input wire logic slotted_mode,
   output logic [15:0] ram_addr,
   output logic ram_rd,
   input wire logic [7:0] ram_rdata,
   output logic ram_wr,
   output logic [7:0] ram_wdata,
   input wire logic [15:0] rx_buf_addr,
   input wire logic [15:0] own_short_addr,
   output logic rx_done,
   output logic tx_done,
   output logic ack_received,
   output logic symbol_tick,
   output logic slot_tick,
   output logic [15:0] tx_stamp,
   output logic trace_frame_signal,
   output logic trace_serial_line,
   input wire logic noise_bit,
   output logic [15:0] noise_random_source
);
   // ------------------------------------------------------------
   // Spreading table
   // ------------------------------------------------------------
   function automatic logic [31:0] spread(input logic [3:0] s);
      logic [31:0] base;
      logic [31:0] r;
      base = 32'hD9C3522E;
      r = (base >> (s[2:0] * 4)) | (base << (32 - s[2:0] * 4));
      if (s[3])
         r = r ^ 32'h55555555;
      return r;
   endfunction : spread

   function automatic logic [3:0] despread(input logic [31:0] c);
      logic [3:0] best;
      logic [5:0] bd;
      logic [5:0] d;
      best = '0;
      bd = 6'h3F;
      for (int k = 0; k < 16; k++)
      begin
         d = 6'($countones(c ^ spread(4'(k))));
         if (d < bd)
         begin
            bd = d;
            best = 4'(k);
         end
      end
      return best;
   endfunction : despread

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++)
         r = (r[0] ^ b[i]) ? ((r >> 1) ^ `LWM_CRC_POLY) : (r >> 1);
      return r;
   endfunction : crc_step

   // ------------------------------------------------------------
   // Symbol timer, gain, strength, assessment
   // ------------------------------------------------------------
   logic [7:0] qcnt_ff, nxt_qcnt;
   logic [1:0] qph_ff, nxt_qph;
   logic [15:0] stamp_ff, nxt_stamp;
   logic [7:0] gain_ff, nxt_gain;
   logic frozen_ff, nxt_frozen;
   logic [10:0] racc_ff, nxt_racc;
   logic [2:0] rwin_ff, nxt_rwin;
   logic [7:0] rssi_ff, nxt_rssi;
   logic [15:0] rnd_ff, nxt_rnd;
   logic qtick, rx_pkt_end;
   logic rx_sym_valid, rx_sym_ready, fifo_v, fifo_rdy;
   logic [3:0] fifo_sym;

   assign qtick = (qcnt_ff == 8'(`LWM_QSYM_CYC - 1));

   always_comb
   begin
      nxt_qcnt = qtick ? 8'h00 : qcnt_ff + 8'h01;
      nxt_qph = qtick ? qph_ff + 2'h1 : qph_ff;
      nxt_stamp = (qtick && qph_ff == 2'h3) ? stamp_ff + 16'h0001 : stamp_ff;
      nxt_frozen = frozen_ff;
      if (preamble_seen)
         nxt_frozen = 1'b1;
      else if (rx_pkt_end)
         nxt_frozen = 1'b0;
      nxt_gain = gain_ff;
      if (qtick && !frozen_ff && !preamble_seen)
      begin
         if (rssi_sample > 8'hC0 && gain_ff != 8'h00)
            nxt_gain = gain_ff - 8'h01;
         else if (rssi_sample < 8'h40 && gain_ff != 8'hFF)
            nxt_gain = gain_ff + 8'h01;
      end
      nxt_racc = racc_ff;
      nxt_rwin = rwin_ff;
      nxt_rssi = rssi_ff;
      if (rx_pkt_end)
      begin
         nxt_rssi = rssi_sample;
         nxt_racc = '0;
         nxt_rwin = '0;
      end
      else if (qtick && qph_ff == 2'h3)
      begin
         nxt_racc = racc_ff + {3'h0, rssi_sample};
         nxt_rwin = rwin_ff + 3'h1;
         if (rwin_ff == 3'(`LWM_RSSI_WIN - 1))
         begin
            nxt_rssi = nxt_racc[10:3];
            nxt_racc = '0;
         end
      end
      nxt_rnd = {rnd_ff[14:0], rnd_ff[15] ^ noise_bit};
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         qcnt_ff <= '0;
         qph_ff <= '0;
         stamp_ff <= '0;
         gain_ff <= 8'h80;
         frozen_ff <= 1'b0;
         racc_ff <= '0;
         rwin_ff <= '0;
         rssi_ff <= '0;
         rnd_ff <= '0;
      end
      else
      begin
         qcnt_ff <= nxt_qcnt;
         qph_ff <= nxt_qph;
         stamp_ff <= nxt_stamp;
         gain_ff <= nxt_gain;
         frozen_ff <= nxt_frozen;
         racc_ff <= nxt_racc;
         rwin_ff <= nxt_rwin;
         rssi_ff <= nxt_rssi;
         rnd_ff <= nxt_rnd;
      end
   end

   assign gain_loop = gain_ff;
   assign rssi_value = rssi_ff;
   assign cca_busy = (rssi_ff > cca_threshold);
   assign symbol_tick = qtick && qph_ff == 2'h3;
   assign slot_tick = symbol_tick && stamp_ff[4:0] == 5'h13;
   assign noise_random_source = rnd_ff;

   // ------------------------------------------------------------
   // Receive symbol buffer
   // ------------------------------------------------------------
   assign rx_sym_valid = rx_chip_valid;
   lwm_fifo #(.WIDTH(4), .DEPTH(`LWM_FIFO_DEPTH)) u_rx_fifo (
      .clk(clk),
      .reset(reset),
      .in_valid(rx_sym_valid),
      .in_ready(rx_sym_ready),
      .in_data(despread(rx_chip_word)),
      .out_valid(fifo_v),
      .out_ready(fifo_rdy),
      .out_data(fifo_sym)
   );

   // ------------------------------------------------------------
   // Transmit and receive MAC
   // ------------------------------------------------------------
   lwm_tx_t tx_ff, nxt_tx;
   lwm_rx_t rx_ff, nxt_rx;
   logic [12:0] tcnt_ff, nxt_tcnt;
   logic [7:0] tlen_ff, nxt_tlen, tidx_ff, nxt_tidx;
   logic [15:0] tcrc_ff, nxt_tcrc, rcrc_ff, nxt_rcrc;
   logic [3:0] tsym_ff, nxt_tsym;
   logic tnib_ff, nxt_tnib, chipv_ff, nxt_chipv, ack_ff, nxt_ack;
   logic [7:0] rlen_ff, nxt_rlen, ridx_ff, nxt_ridx, rbyte_ff, nxt_rbyte;
   logic rnib_ff, nxt_rnib, racc_ok_ff, nxt_racc_ok;
   logic [15:0] raddr_ff, nxt_raddr;
   logic [7:0] wdata_ff, nxt_wdata;
   logic wr_ff, nxt_wr;
   logic rd_ff, nxt_rd;
   logic [15:0] tstamp_ff, nxt_tstamp;
   logic rxdone_ff, nxt_rxdone, txdone_ff, nxt_txdone, ackrx_ff, nxt_ackrx;
   logic [7:0] tbyte;
   localparam logic [7:0] SFD_CODE = `LWM_SFD;

   assign tbyte = ram_rdata;
   assign rx_pkt_end = rxdone_ff;
   assign fifo_rdy = (tx_ff == LWM_TX_IDLE || tx_ff == LWM_TX_WAIT_ACK) && !wr_ff;

   always_comb
   begin
      nxt_tx = tx_ff; nxt_tcnt = tcnt_ff; nxt_tlen = tlen_ff; nxt_tidx = tidx_ff;
      nxt_tcrc = tcrc_ff; nxt_tsym = tsym_ff; nxt_tnib = tnib_ff; nxt_chipv = 1'b0;
      nxt_ack = ack_ff; nxt_rd = 1'b0; nxt_tstamp = tstamp_ff; nxt_txdone = 1'b0;
      nxt_ackrx = 1'b0;
      nxt_tcnt = (tcnt_ff != '0) ? tcnt_ff - 13'h0001 : '0;
      case (tx_ff)
         LWM_TX_IDLE:
            if (tx_start)
            begin
               nxt_tx = LWM_TX_BACKOFF;
               nxt_tcnt = 13'(`LWM_BACKOFF_CYC);
               nxt_tidx = '0;
            end
         LWM_TX_BACKOFF:
            if (tcnt_ff == '0 && (!slotted_mode || symbol_tick))
               nxt_tx = LWM_TX_CCA;
         LWM_TX_CCA:
            if (cca_busy)
            begin
               nxt_tx = LWM_TX_BACKOFF;
               nxt_tcnt = 13'(`LWM_BACKOFF_CYC);
            end
            else
            begin
               nxt_tx = LWM_TX_PRE;
               nxt_tidx = '0;
               nxt_tstamp = stamp_ff;
               nxt_rd = 1'b1;
            end
         default:
            if (tx_ff == LWM_TX_WAIT_ACK)
            begin
               if (tcnt_ff == '0)
               begin
                  nxt_tx = LWM_TX_IDLE;
                  nxt_txdone = 1'b1;
               end
            end
            else if (tcnt_ff == '0 && tx_ff == LWM_TX_CRC && tidx_ff == 8'h04)
            begin
               nxt_tx = LWM_TX_WAIT_ACK;
               nxt_tcnt = 13'(`LWM_BACKOFF_CYC);
            end
            else if (tcnt_ff == '0)
            begin
               nxt_tcnt = 13'(`LWM_CHIP_CYC * 32 - 1);
               nxt_chipv = 1'b1;
               nxt_tnib = !tnib_ff;
               if (tx_ff == LWM_TX_PRE)
               begin
                  nxt_tsym = (tidx_ff < 8'(`LWM_PRE_SYMS)) ? 4'h0
                     : (tnib_ff ? SFD_CODE[7:4] : SFD_CODE[3:0]);
                  if (tidx_ff == 8'(`LWM_PRE_SYMS + 1))
                  begin
                     nxt_tx = LWM_TX_DATA;
                     nxt_tidx = '0;
                     nxt_tlen = tbyte;
                     nxt_tcrc = '0;
                  end
                  else
                     nxt_tidx = tidx_ff + 8'h01;
               end
               else if (tx_ff == LWM_TX_DATA)
               begin
                  nxt_tsym = tnib_ff ? tbyte[7:4] : tbyte[3:0];
                  if (tnib_ff)
                  begin
                     // Length byte stays out of the check sequence
                     if (tidx_ff != 8'h00)
                        nxt_tcrc = crc_step(tcrc_ff, tbyte);
                     if (tidx_ff == 8'h01)
                        nxt_ack = tbyte[5];
                     nxt_tidx = tidx_ff + 8'h01;
                     nxt_rd = 1'b1;
                     if (tidx_ff == tlen_ff - 8'h02)
                     begin
                        nxt_tx = LWM_TX_CRC;
                        nxt_tidx = '0;
                     end
                  end
               end
               else
               begin
                  nxt_tsym = tcrc_ff[4 * tidx_ff[1:0] +: 4];
                  nxt_tidx = tidx_ff + 8'h01;
               end
            end
      endcase
      if (tx_ff == LWM_TX_WAIT_ACK && ack_ff && rxdone_ff && rlen_ff == 8'h05)
      begin
         nxt_ackrx = 1'b1;
         nxt_tx = LWM_TX_IDLE;
         nxt_txdone = 1'b1;
      end
   end

   always_comb
   begin
      nxt_rx = rx_ff; nxt_rlen = rlen_ff; nxt_ridx = ridx_ff; nxt_rbyte = rbyte_ff;
      nxt_rnib = rnib_ff; nxt_rcrc = rcrc_ff; nxt_raddr = raddr_ff; nxt_wr = 1'b0;
      nxt_wdata = wdata_ff; nxt_rxdone = 1'b0; nxt_racc_ok = racc_ok_ff;
      case (rx_ff)
         LWM_RX_HUNT:
            if (fifo_v && fifo_rdy && preamble_seen)
            begin
               nxt_rx = LWM_RX_LEN;
               nxt_rnib = 1'b0;
               nxt_rcrc = '0;
               nxt_ridx = '0;
               nxt_racc_ok = 1'b1;
               nxt_raddr = rx_buf_addr;
            end
         LWM_RX_LEN, LWM_RX_BODY:
            if (fifo_v && fifo_rdy)
            begin
               nxt_rnib = !rnib_ff;
               if (!rnib_ff)
                  nxt_rbyte = {4'h0, fifo_sym};
               else
               begin
                  nxt_rbyte = {fifo_sym, rbyte_ff[3:0]};
                  if (rx_ff == LWM_RX_LEN)
                  begin
                     nxt_rlen = nxt_rbyte;
                     nxt_rx = LWM_RX_BODY;
                  end
                  else
                  begin
                     nxt_rcrc = crc_step(rcrc_ff, nxt_rbyte);
                     nxt_ridx = ridx_ff + 8'h01;
                     if (ridx_ff == 8'h05 && nxt_rbyte != own_short_addr[7:0])
                        nxt_racc_ok = 1'b0;
                     if (ridx_ff == 8'h06 && nxt_rbyte != own_short_addr[15:8])
                        nxt_racc_ok = 1'b0;
                     nxt_wr = racc_ok_ff;
                     nxt_wdata = nxt_rbyte;
                     nxt_raddr = raddr_ff + 16'h0001;
                     if (ridx_ff == rlen_ff - 8'h01)
                     begin
                        nxt_rx = LWM_RX_STAT;
                        nxt_ridx = '0;
                     end
                  end
               end
            end
         default:
         begin
            nxt_ridx = ridx_ff + 8'h01;
            nxt_raddr = raddr_ff + 16'h0001;
            nxt_wr = racc_ok_ff;
            case (ridx_ff[2:0])
               3'h0: nxt_wdata = 8'hFF - rssi_sample;
               3'h1: nxt_wdata = rssi_sample;
               3'h2: nxt_wdata = gain_ff;
               3'h3: nxt_wdata = stamp_ff[7:0];
               default: nxt_wdata = {6'h00, ack_ff, rcrc_ff == 16'h0000};
            endcase
            if (ridx_ff == 8'(`LWM_STAT_BYTES - 1))
            begin
               nxt_rx = LWM_RX_HUNT;
               nxt_rxdone = racc_ok_ff;
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         tx_ff <= LWM_TX_IDLE; tcnt_ff <= '0; tlen_ff <= '0; tidx_ff <= '0;
         tcrc_ff <= '0; tsym_ff <= '0; tnib_ff <= 1'b0; chipv_ff <= 1'b0;
         ack_ff <= 1'b0; rd_ff <= 1'b0; tstamp_ff <= '0; txdone_ff <= 1'b0;
         ackrx_ff <= 1'b0; rx_ff <= LWM_RX_HUNT; rlen_ff <= '0; ridx_ff <= '0;
         rbyte_ff <= '0; rnib_ff <= 1'b0; rcrc_ff <= '0; raddr_ff <= '0;
         wr_ff <= 1'b0; wdata_ff <= '0; rxdone_ff <= 1'b0; racc_ok_ff <= 1'b0;
      end
      else
      begin
         tx_ff <= nxt_tx; tcnt_ff <= nxt_tcnt; tlen_ff <= nxt_tlen; tidx_ff <= nxt_tidx;
         tcrc_ff <= nxt_tcrc; tsym_ff <= nxt_tsym; tnib_ff <= nxt_tnib;
         chipv_ff <= nxt_chipv; ack_ff <= nxt_ack; rd_ff <= nxt_rd;
         tstamp_ff <= nxt_tstamp; txdone_ff <= nxt_txdone; ackrx_ff <= nxt_ackrx;
         rx_ff <= nxt_rx; rlen_ff <= nxt_rlen; ridx_ff <= nxt_ridx;
         rbyte_ff <= nxt_rbyte; rnib_ff <= nxt_rnib; rcrc_ff <= nxt_rcrc;
         raddr_ff <= nxt_raddr; wr_ff <= nxt_wr; wdata_ff <= nxt_wdata;
         rxdone_ff <= nxt_rxdone; racc_ok_ff <= nxt_racc_ok;
      end
   end

   assign tx_chip_valid = chipv_ff;
   assign tx_chip_word = spread(tsym_ff);
   assign pa_transmit_indicator = (tx_ff != LWM_TX_IDLE && tx_ff != LWM_TX_BACKOFF
      && tx_ff != LWM_TX_WAIT_ACK);
   assign pa_transmit_indicator_inverted = !pa_transmit_indicator;
   assign ram_addr = wr_ff ? raddr_ff : tx_buf_addr + {8'h00, tidx_ff};
   assign ram_rd = rd_ff;
   assign ram_wr = wr_ff;
   assign ram_wdata = wdata_ff;
   assign rx_done = rxdone_ff;
   assign tx_done = txdone_ff;
   assign ack_received = ackrx_ff;
   assign tx_stamp = tstamp_ff;

   // ------------------------------------------------------------
   // Trace serialiser, observe only
   // ------------------------------------------------------------
   logic [5:0] bcnt_ff, nxt_bcnt;
   logic [8:0] tsh_ff, nxt_tsh;
   logic [3:0] tbits_ff, nxt_tbits;
   logic tfr_ff, nxt_tfr;
   logic tev;
   logic [3:0] tdat;

   // Copies symbols seen on both directions; no path back in
   assign tev = chipv_ff || (fifo_v && fifo_rdy);
   assign tdat = chipv_ff ? tsym_ff : fifo_sym;

   always_comb
   begin
      nxt_tfr = pa_transmit_indicator || rx_ff != LWM_RX_HUNT || tev || tbits_ff != 4'h0;
      nxt_bcnt = (bcnt_ff == 6'(`LWM_TRACE_CYC - 1)) ? 6'h00 : bcnt_ff + 6'h01;
      nxt_tsh = tsh_ff;
      nxt_tbits = tbits_ff;
      if (tev && tbits_ff == 4'h0)
      begin
         nxt_tsh = {3'h7, tdat, 1'b0, 1'b1};
         nxt_tbits = 4'h7;
      end
      else if (bcnt_ff == 6'h00 && tbits_ff != 4'h0)
      begin
         nxt_tsh = {1'b1, tsh_ff[8:1]};
         nxt_tbits = tbits_ff - 4'h1;
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         bcnt_ff <= '0;
         tsh_ff <= 9'h1FF;
         tbits_ff <= '0;
         tfr_ff <= 1'b0;
      end
      else
      begin
         bcnt_ff <= nxt_bcnt;
         tsh_ff <= nxt_tsh;
         tbits_ff <= nxt_tbits;
         tfr_ff <= nxt_tfr;
      end
   end

   assign trace_frame_signal = tfr_ff;
   assign trace_serial_line = tsh_ff[0];
endmodule : lwm_mac_baseband

// *** lwm_ram_model.sv ***
// ----------------------------------------
// Packet RAM seen through the MAC DMA port
// ----------------------------------------
module lwm_ram_model (
   input wire logic clk,
   input wire logic [15:0] ram_addr,
   input wire logic ram_rd,
   output logic [7:0] ram_rdata,
   input wire logic ram_wr,
   input wire logic [7:0] ram_wdata
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mem [0:255];
   initial ram_rdata = 8'h5A;
   // Read data lands one cycle after the strobe and is held
   always @(posedge clk)
   begin
      if (ram_rd)
         ram_rdata <= mem[ram_addr[7:0]];
      if (ram_wr)
         mem[ram_addr[7:0]] <= ram_wdata;
   end
endmodule : lwm_ram_model

// *** lwm_mac_baseband_assertions.sv ***
module lwm_mac_baseband_checker (
   input wire logic clk,
   input wire logic reset,
   input wire logic preamble_seen,
   input wire logic [7:0] cca_threshold,
   input wire logic [7:0] gain_loop,
   input wire logic [7:0] rssi_value,
   input wire logic cca_busy,
   input wire logic tx_chip_valid,
   input wire logic pa_transmit_indicator,
   input wire logic pa_transmit_indicator_inverted,
   input wire logic ram_rd,
   input wire logic trace_frame_signal,
   input wire logic trace_serial_line
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // ----------------------------------------
   // Cycles since the gain last moved
   // ----------------------------------------
   logic [7:0] prev_ff, nxt_prev;
   logic [9:0] gap_ff, nxt_gap;
   always_comb
   begin
      nxt_prev = gain_loop;
      nxt_gap = (gain_loop != prev_ff) ? 10'h000 : gap_ff + ((gap_ff == 10'h3FF) ? 10'h0 : 10'h1);
   end
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         prev_ff <= 8'h80;
         gap_ff <= 10'h000;
      end
      else
      begin
         prev_ff <= nxt_prev;
         gap_ff <= nxt_gap;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_inv;
      pa_transmit_indicator_inverted == !pa_transmit_indicator;
   endproperty
   a_inv: assert property (p_inv) else $error("companion not inverse");
   property p_gain_step;
      $changed(gain_loop) |-> (8'(gain_loop - $past(gain_loop)) inside {8'h01, 8'hFF});
   endproperty
   a_gain_step: assert property (p_gain_step) else $error("gain step not one");
   property p_gain_gap;
      (gain_loop != prev_ff) |-> gap_ff >= 10'd99;
   endproperty
   a_gain_gap: assert property (p_gain_gap) else $error("gain moved too soon");
   property p_gain_hold;
      preamble_seen && $past(preamble_seen) |-> $stable(gain_loop);
   endproperty
   a_gain_hold: assert property (p_gain_hold) else $error("gain moved in packet");
   property p_cca;
      cca_busy == (rssi_value > cca_threshold);
   endproperty
   a_cca: assert property (p_cca) else $error("cca verdict wrong");
   property p_chip_gap;
      tx_chip_valid |=> !tx_chip_valid [*8];
   endproperty
   a_chip_gap: assert property (p_chip_gap) else $error("chips too close");
   property p_chip_tx;
      tx_chip_valid || ram_rd |-> pa_transmit_indicator;
   endproperty
   a_chip_tx: assert property (p_chip_tx) else $error("tx work in rx mode");
   property p_trace_idle;
      !trace_frame_signal && $past(!trace_frame_signal) |-> trace_serial_line;
   endproperty
   a_trace_idle: assert property (p_trace_idle) else $error("trace not idle");
   property p_trace_bit;
      $changed(trace_serial_line) |=> $stable(trace_serial_line) [*8];
   endproperty
   a_trace_bit: assert property (p_trace_bit) else $error("trace bit short");
endmodule : lwm_mac_baseband_checker
bind lwm_mac_baseband lwm_mac_baseband_checker i_chk (.clk(clk), .reset(reset),
   .preamble_seen(preamble_seen), .cca_threshold(cca_threshold), .gain_loop(gain_loop),
   .rssi_value(rssi_value), .cca_busy(cca_busy), .tx_chip_valid(tx_chip_valid),
   .pa_transmit_indicator(pa_transmit_indicator),
   .pa_transmit_indicator_inverted(pa_transmit_indicator_inverted), .ram_rd(ram_rd),
   .trace_frame_signal(trace_frame_signal), .trace_serial_line(trace_serial_line));

// *** lwm_mac_baseband_bench.sv ***
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module lwm_mac_baseband_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, reset = 1, rx_chip_valid = 0, preamble_seen = 0, tx_start = 0;
   logic slotted_mode = 0, noise_bit = 0;
   logic [31:0] rx_chip_word = 32'h0;
   logic [7:0] rssi_sample = 8'h10, cca_threshold = 8'hFF, gain_loop, rssi_value, ram_rdata;
   logic [7:0] ram_wdata;
   logic [15:0] tx_buf_addr = 16'h0040, rx_buf_addr = 16'h0080, own_short_addr = 16'h1234;
   logic [15:0] ram_addr, noise_random_source;
   logic cca_busy, tx_chip_valid, pa_transmit_indicator, pa_transmit_indicator_inverted;
   logic ram_rd, ram_wr, trace_frame_signal, trace_serial_line, tx_done, rx_done;
   logic [31:0] tx_chip_word;
   int miscompares = 0, samples_checked = 0;
   always #20 clk = ~clk;
   lwm_mac_baseband i_dut (.clk(clk), .reset(reset), .rx_chip_valid(rx_chip_valid),
      .rx_chip_word(rx_chip_word), .preamble_seen(preamble_seen), .rssi_sample(rssi_sample),
      .cca_threshold(cca_threshold), .gain_loop(gain_loop), .rssi_value(rssi_value),
      .cca_busy(cca_busy), .tx_chip_valid(tx_chip_valid), .tx_chip_word(tx_chip_word),
      .pa_transmit_indicator(pa_transmit_indicator),
      .pa_transmit_indicator_inverted(pa_transmit_indicator_inverted), .tx_start(tx_start),
      .tx_buf_addr(tx_buf_addr), .slotted_mode(slotted_mode), .ram_addr(ram_addr),
      .ram_rd(ram_rd), .ram_rdata(ram_rdata), .ram_wr(ram_wr), .ram_wdata(ram_wdata),
      .rx_buf_addr(rx_buf_addr), .own_short_addr(own_short_addr), .rx_done(rx_done),
      .tx_done(tx_done), .ack_received(), .symbol_tick(), .slot_tick(), .tx_stamp(),
      .trace_frame_signal(trace_frame_signal), .trace_serial_line(trace_serial_line),
      .noise_bit(noise_bit), .noise_random_source(noise_random_source));
   lwm_ram_model i_ram (.clk(clk), .ram_addr(ram_addr), .ram_rd(ram_rd),
      .ram_rdata(ram_rdata), .ram_wr(ram_wr), .ram_wdata(ram_wdata));
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task t_reset;
      `CHK("gain", 8'h80, gain_loop)
      `CHK("tx_ind", 1'b0, pa_transmit_indicator)
      `CHK("tx_ind_n", 1'b1, pa_transmit_indicator_inverted)
      `CHK("trace", 1'b1, trace_serial_line)
   endtask : t_reset
   task t_gain;
      logic [7:0] g;
      tick(250);
      // Direction depends on level; two quarter-symbol steps either way
      `CHK("gain_free", 1'b1, gain_loop inside {8'h82, 8'h7E})
      preamble_seen = 1;
      tick(2);
      g = gain_loop;
      tick(300);
      `CHK("gain_frozen", g, gain_loop)
      preamble_seen = 0;
   endtask : t_gain
   task t_cca;
      rssi_sample = 8'h80;
      cca_threshold = 8'h80;
      tick(6000);
      `CHK("rssi_avg", 8'h80, rssi_value)
      `CHK("cca_clear", 1'b0, cca_busy)
      cca_threshold = 8'h7F;
      tick(1);
      `CHK("cca_busy", 1'b1, cca_busy)
      cca_threshold = 8'hFF;
   endtask : t_cca
   task t_noise;
      noise_bit = 1;
      tick(16);
      `CHK("noise1", 16'hFFFF, noise_random_source)
      tick(16);
      `CHK("noise0", 16'h0000, noise_random_source)
      noise_bit = 0;
   endtask : t_noise
   task t_rx;
      logic got;
      got = 0;
      preamble_seen = 1;
      rx_chip_valid = 1;
      for (int i = 0; i < 13; i++)
      begin
         rx_chip_word = (i == 1) ? 32'h3522ED9C : 32'hD9C3522E;
         tick(1);
      end
      rx_chip_valid = 0;
      for (int i = 0; i < 60; i++)
      begin
         tick(1);
         got |= rx_done;
      end
      preamble_seen = 0;
      `CHK("rx_done", 1'b1, got)
      `CHK("rx_byte", 8'h00, i_ram.mem[8'h85])
      `CHK("rx_stat", 8'h01, i_ram.mem[8'h8A])
   endtask : t_rx
   task t_tx;
      logic [31:0] w [0:9];
      logic [15:0] a;
      logic seen_rd, seen_tr, done;
      int n;
      n = 0;
      seen_rd = 0;
      seen_tr = 0;
      done = 0;
      a = 16'hFFFF;
      i_ram.mem[8'h40] = 8'h04;
      i_ram.mem[8'h41] = 8'h01;
      i_ram.mem[8'h42] = 8'h00;
      tx_start = 1;
      tick(1);
      tx_start = 0;
      for (int i = 0; i < 40000 && !done; i++)
      begin
         tick(1);
         if (tx_chip_valid && n < 10)
         begin
            w[n] = tx_chip_word;
            n++;
         end
         if (ram_rd && !seen_rd)
         begin
            a = ram_addr;
            seen_rd = 1;
         end
         seen_tr |= trace_frame_signal;
         done = tx_done;
      end
      `CHK("tx_done", 1'b1, done)
      `CHK("first_rd", tx_buf_addr, a)
      `CHK("chips", 10, n)
      `CHK("preamble", 32'hD9C3522E, w[7])
      `CHK("sfd_lo", 32'h9C3522ED, w[8])
      `CHK("sfd_hi", 32'h7B8C9607, w[9])
      `CHK("trace_seen", 1'b1, seen_tr)
      tick(2);
      `CHK("tx_ind_off", 1'b0, pa_transmit_indicator)
   endtask : t_tx
   task results;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : results
   initial
   begin
      tick(5);
      reset = 0;
      t_reset();
      t_gain();
      t_cca();
      t_noise();
      t_rx();
      t_tx();
      results();
   end
endmodule : lwm_mac_baseband_bench
